// ---- core/dss_dec_if.sv ----
// Decoded store instruction passed from the decoder to the execute stage.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface dss_dec_if;
  dss_pkg::dss_kind_t kind;
  logic [4:0]         base_sel;
  logic [4:0]         src_sel;
  logic [63:0]        sext_ofs;
  logic [1:0]         cop_num;
  logic               rsv_inst;
  modport dec (output kind, output base_sel, output src_sel, output sext_ofs, output cop_num, output rsv_inst);
  modport exe (input kind, input base_sel, input src_sel, input sext_ofs, input cop_num, input rsv_inst);
endinterface : dss_dec_if

// ---- core/dss_decode.sv ----
// Combinational opcode decoder for the doubleword store family.
// Assumes the instruction word is already registered in the caller's domain.
`timescale 1ns/1ps
module dss_decode (
  input  wire logic [31:0] instr_word,
  input  wire logic        instr_valid,
  dss_dec_if.dec           dec
);
  logic [5:0] opc;
  assign opc = instr_word[dss_pkg::OP_MSB:dss_pkg::OP_LSB];

  // Opcode classification; coprocessor 0 slot is left to other instructions
  always_comb begin
    dec.kind     = dss_pkg::DST_NONE;
    dec.rsv_inst = 1'b0;
    if (!instr_valid) begin
      dec.kind = dss_pkg::DST_NONE;
    end else if (opc == dss_pkg::OP_COND_DST) begin
      dec.kind = dss_pkg::DST_COND;
    end else if (opc == dss_pkg::OP_PLAIN_DST) begin
      dec.kind = dss_pkg::DST_PLAIN;
    end else if (opc == dss_pkg::OP_LEFT_DST) begin
      dec.kind = dss_pkg::DST_LEFT;
    end else if (opc[5:2] == dss_pkg::OP_COP_HI && opc[1:0] != 2'h0) begin
      dec.kind = dss_pkg::DST_COP;
    end
  end

  // Field extraction with sign extension of the offset
  assign dec.base_sel = instr_word[dss_pkg::BASE_MSB:dss_pkg::BASE_LSB];
  assign dec.src_sel  = instr_word[dss_pkg::SRC_MSB:dss_pkg::SRC_LSB];
  assign dec.sext_ofs = {{48{instr_word[dss_pkg::OFS_MSB]}}, instr_word[15:0]};
  assign dec.cop_num  = opc[1:0];
endmodule : dss_decode

// ---- core/dss_pkg.sv ----
// Shared constants and types for the doubleword store unit.
// Assumes a 64-bit core with 32-bit instruction words and a 4-way coprocessor space.
package dss_pkg;
  localparam int          XLEN         = 64;
  localparam logic [5:0]  OP_COND_DST  = 6'h3C;  // 111100
  localparam logic [5:0]  OP_PLAIN_DST = 6'h3F;  // 111111
  localparam logic [5:0]  OP_LEFT_DST  = 6'h2C;  // 101100
  localparam logic [3:0]  OP_COP_HI    = 4'hF;   // 1111zz
  localparam int          OP_MSB       = 31;
  localparam int          OP_LSB       = 26;
  localparam int          BASE_MSB     = 25;
  localparam int          BASE_LSB     = 21;
  localparam int          SRC_MSB      = 20;
  localparam int          SRC_LSB      = 16;
  localparam int          OFS_MSB      = 15;
  localparam int          ALIGN_BITS   = 3;
  localparam int          NUM_COP      = 4;
  localparam logic [3:0]  EXC_NONE     = 4'h0;
  localparam logic [3:0]  EXC_ADDR_ERR = 4'h1;
  localparam logic [3:0]  EXC_COP_UNUS = 4'h2;
  localparam logic [3:0]  EXC_RSV_INST = 4'h3;
  localparam logic [3:0]  EXC_TLB_REF  = 4'h4;
  localparam logic [3:0]  EXC_TLB_INV  = 4'h5;
  localparam logic [3:0]  EXC_TLB_MOD  = 4'h6;

  typedef enum logic [2:0] {
    DST_NONE,
    DST_COND,
    DST_PLAIN,
    DST_COP,
    DST_LEFT
  } dss_kind_t;
endpackage : dss_pkg

// ---- core/dss_store_unit.sv ----
// Execute-stage logic for the doubleword store family and the link reservation.
// Assumes the register file, translation and coprocessors answer combinationally
// in the issue cycle; results appear one cycle later from flip-flops.
`timescale 1ns/1ps
module dss_store_unit #(
  parameter int BLK_BITS = 5 // Reservation block is one cache line of 32 bytes
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] instr_word,
  input  wire logic        instr_valid,
  input  wire logic        big_endian,
  input  wire logic [63:0] base_val,
  input  wire logic [63:0] src_val,
  input  wire logic [63:0] cop_data,
  input  wire logic [3:0]  cop_usable,
  input  wire logic [63:0] phys_addr,
  input  wire logic        tlb_refill,
  input  wire logic        tlb_invalid,
  input  wire logic        tlb_modified,
  input  wire logic        linked_load,
  input  wire logic [63:0] linked_paddr,
  input  wire logic        exc_taken,
  input  wire logic        sysctl_event,
  input  wire logic        snoop_store,
  input  wire logic [63:0] snoop_paddr,
  output logic [4:0]       base_sel,
  output logic [4:0]       src_sel,
  output logic [1:0]       cop_num,
  output logic             mem_wr,
  output logic [63:0]      mem_addr,
  output logic [63:0]      mem_data,
  output logic [7:0]       mem_be,
  output logic             gpr_wr,
  output logic [4:0]       gpr_dst,
  output logic [63:0]      gpr_data,
  output logic             exc_valid,
  output logic [3:0]       exc_code,
  output logic [63:0]      bad_vaddr,
  output logic             link_flag
);
  typedef struct packed {
    logic        mem_wr;
    logic [63:0] mem_addr;
    logic [63:0] mem_data;
    logic [7:0]  mem_be;
    logic        gpr_wr;
    logic [4:0]  gpr_dst;
    logic [63:0] gpr_data;
    logic        exc_valid;
    logic [3:0]  exc_code;
    logic [63:0] bad_vaddr;
    logic        link;
    logic [63:0] link_pa;
  } dss_state_t;

  dss_state_t state_ff;
  dss_state_t nxt_state;
  dss_dec_if  dec_bus ();

  logic [63:0] eff_addr;
  logic        misalign;
  logic        tlb_fault;
  logic [2:0]  lane;
  logic [7:0]  left_be;
  logic [63:0] left_data;
  logic        snoop_hit;

  dss_decode u_dec (
    .instr_word  (instr_word),
    .instr_valid (instr_valid),
    .dec         (dec_bus)
  );

  // Register file and coprocessor selects are combinational requests
  assign base_sel = dec_bus.base_sel;
  assign src_sel  = dec_bus.src_sel;
  assign cop_num  = dec_bus.cop_num;

  // Address formation and alignment check
  assign eff_addr  = dec_bus.sext_ofs + base_val;
  assign misalign  = |eff_addr[dss_pkg::ALIGN_BITS-1:0];
  assign tlb_fault = tlb_refill | tlb_invalid | tlb_modified;
  // Only coherent snooped stores are visible; noncoherent I/O never reaches this port
  assign snoop_hit = snoop_store &&
                     (snoop_paddr[63:BLK_BITS] == state_ff.link_pa[63:BLK_BITS]);

  // Left-part lane choice: big-endian keeps lanes from the offset upward to
  // the low end; little-endian flips the offset first
  assign lane = big_endian ? eff_addr[2:0] : ~eff_addr[2:0];
  always_comb begin
    left_be   = 8'hFF >> lane;
    left_data = src_val >> {lane, 3'h0};
  end

  // Next-state: one instruction per cycle, all outputs but the register and coprocessor selects registered
  always_comb begin
    nxt_state           = state_ff;
    nxt_state.mem_wr    = 1'b0;
    nxt_state.gpr_wr    = 1'b0;
    nxt_state.exc_valid = 1'b0;
    nxt_state.exc_code  = dss_pkg::EXC_NONE;
    // Reservation tracking; a new linked load wins over an exc_taken, sysctl_event or snoop_hit clear in the same cycle
    if (exc_taken || sysctl_event || snoop_hit) begin
      nxt_state.link = 1'b0;
    end
    if (linked_load) begin
      nxt_state.link    = 1'b1;
      nxt_state.link_pa = linked_paddr;
    end
    if (dec_bus.kind != dss_pkg::DST_NONE) begin
      nxt_state.mem_addr = {phys_addr[63:3], 3'h0};
      nxt_state.mem_be   = 8'hFF;
      if (dec_bus.kind == dss_pkg::DST_COP && !cop_usable[dec_bus.cop_num]) begin
        nxt_state.exc_valid = 1'b1;
        nxt_state.exc_code  = dss_pkg::EXC_COP_UNUS;
      end else if (dec_bus.kind != dss_pkg::DST_LEFT && misalign) begin
        nxt_state.exc_valid = 1'b1;
        nxt_state.exc_code  = dss_pkg::EXC_ADDR_ERR;
        nxt_state.bad_vaddr = eff_addr;
      end else if (tlb_fault) begin
        nxt_state.exc_valid = 1'b1;
        nxt_state.exc_code  = tlb_refill ? dss_pkg::EXC_TLB_REF :
                              (tlb_invalid ? dss_pkg::EXC_TLB_INV : dss_pkg::EXC_TLB_MOD);
        nxt_state.bad_vaddr = eff_addr;
      end else begin
        case (dec_bus.kind)
          dss_pkg::DST_COND: begin
            // Success needs the flag still standing after this cycle's clears
            nxt_state.mem_wr   = state_ff.link && !(exc_taken || sysctl_event || snoop_hit);
            nxt_state.mem_data = src_val;
            nxt_state.gpr_wr   = 1'b1;
            nxt_state.gpr_dst  = dec_bus.src_sel;
            nxt_state.gpr_data = {63'h0, nxt_state.mem_wr};
            nxt_state.link     = 1'b0;
          end
          dss_pkg::DST_PLAIN: begin
            nxt_state.mem_wr   = 1'b1;
            nxt_state.mem_data = src_val;
          end
          dss_pkg::DST_COP: begin
            nxt_state.mem_wr   = 1'b1;
            nxt_state.mem_data = cop_data;
          end
          dss_pkg::DST_LEFT: begin
            nxt_state.mem_wr   = 1'b1;
            nxt_state.mem_data = left_data;
            nxt_state.mem_be   = left_be;
          end
          default: begin
            nxt_state.mem_wr = 1'b0;
          end
        endcase
      end
      if (nxt_state.exc_valid) begin
        nxt_state.link = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign mem_wr    = state_ff.mem_wr;
  assign mem_addr  = state_ff.mem_addr;
  assign mem_data  = state_ff.mem_data;
  assign mem_be    = state_ff.mem_be;
  assign gpr_wr    = state_ff.gpr_wr;
  assign gpr_dst   = state_ff.gpr_dst;
  assign gpr_data  = state_ff.gpr_data;
  assign exc_valid = state_ff.exc_valid;
  assign exc_code  = state_ff.exc_code;
  assign bad_vaddr = state_ff.bad_vaddr;
  assign link_flag = state_ff.link;

  misalign_trap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dec_bus.kind == dss_pkg::DST_PLAIN && misalign && !tlb_fault) |=> exc_valid && !mem_wr
    && exc_code == dss_pkg::EXC_ADDR_ERR) else $error("misaligned store not trapped");
  cond_result_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    gpr_wr |-> gpr_data == {63'h0, mem_wr}) else $error("conditional result mismatch");
  exc_fails_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (exc_taken && !linked_load) |=> !link_flag) else $error("flag survived exception");
  plain_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dec_bus.kind == dss_pkg::DST_PLAIN && !misalign && !tlb_fault) |=> mem_wr
    && mem_data == $past(src_val) && mem_be == 8'hFF) else $error("plain store lost");
  cop_unusable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dec_bus.kind == dss_pkg::DST_COP && !cop_usable[dec_bus.cop_num]) |=> !mem_wr
    && exc_code == dss_pkg::EXC_COP_UNUS) else $error("unusable coprocessor stored");
  snoop_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (snoop_hit && !linked_load) |=> !link_flag) else $error("snoop did not clear flag");
  link_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    linked_load |=> link_flag) else $error("linked load did not set flag");
  left_lanes_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dec_bus.kind == dss_pkg::DST_LEFT && !tlb_fault) |=> mem_wr && mem_be[0]) else $error("left store lanes wrong");
  exc_kinds_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    exc_valid |-> exc_code != dss_pkg::EXC_NONE) else $error("exception without code");
endmodule : dss_store_unit

// ---- verification/dss_far_model.sv ----
// Far-side model of the store unit: register file, address translation, coprocessor data.
// Assumes the unit reads all of these combinationally in the issue cycle.
`timescale 1ns/1ps
module dss_far_model #(
  parameter logic [63:0] PA_FLIP = 64'h0000_00F0_0000_0000
) (
  input  wire logic [31:0] instr_word,
  input  wire logic [4:0]  base_sel,
  input  wire logic [4:0]  src_sel,
  input  wire logic [1:0]  cop_num,
  output logic [63:0]      base_val,
  output logic [63:0]      src_val,
  output logic [63:0]      cop_data,
  output logic [63:0]      phys_addr
);
  logic [63:0] general_register_file [32];
  logic [63:0] cop [4];

  // Known contents from time zero so no unknown reaches the unit
  initial begin
    for (int i = 0; i < 32; i++) general_register_file[i] = 64'h0;
    for (int i = 0; i < 4; i++) cop[i] = 64'h0;
  end

  // Same-cycle answers; every coprocessor is implemented, so any usable bit is legal
  assign base_val = general_register_file[base_sel];
  assign src_val  = general_register_file[src_sel];
  assign cop_data = cop[cop_num];
  // High bits flipped so physical and virtual differ; all pages cached, one type
  assign phys_addr = (base_val + {{48{instr_word[15]}}, instr_word[15:0]}) ^ PA_FLIP;
endmodule : dss_far_model

// ---- verification/tb_dss_store_unit.sv ----
// Self-checking bench for the doubleword store unit, random and corner stores.
// Assumes the far-side model supplies registers, translation and coprocessor data.
`timescale 1ns/1ps
module tb_dss_store_unit;
  localparam logic [63:0] PA_FLIP = 64'h0000_00F0_0000_0000;
  localparam logic [63:0] LBASE   = 64'h0000_0000_0002_0040;
  logic        sys_clk, sys_rst, instr_valid, big_endian, linked_load, exc_taken, sysctl_event;
  logic        snoop_store, tlb_refill, tlb_invalid, tlb_modified, mem_wr, gpr_wr, exc_valid, link_flag, ok;
  logic [31:0] instr_word;
  logic [63:0] base_val, src_val, cop_data, phys_addr, linked_paddr, snoop_paddr;
  logic [63:0] mem_addr, mem_data, gpr_data, bad_vaddr, rnd, src, va, bva;
  logic [4:0]  base_sel, src_sel, gpr_dst;
  logic [3:0]  cop_usable, exc_code;
  logic [71:0] lx;
  logic [1:0]  cop_num;
  logic [7:0]  mem_be;
  int          failures, n_tests;

  dss_store_unit #(.BLK_BITS(5)) dss_store_unit_inst (.sys_clk, .sys_rst, .instr_word, .instr_valid,
    .big_endian, .base_val, .src_val, .cop_data, .cop_usable, .phys_addr, .tlb_refill, .tlb_invalid,
    .tlb_modified, .linked_load, .linked_paddr, .exc_taken, .sysctl_event, .snoop_store, .snoop_paddr,
    .base_sel, .src_sel, .cop_num, .mem_wr, .mem_addr, .mem_data, .mem_be, .gpr_wr, .gpr_dst, .gpr_data,
    .exc_valid, .exc_code, .bad_vaddr, .link_flag);
  dss_far_model #(.PA_FLIP(PA_FLIP)) dss_far_model_inst (.instr_word, .base_sel, .src_sel, .cop_num,
    .base_val, .src_val, .cop_data, .phys_addr);

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [63:0] lfsr(input logic [63:0] s);
    return {s[62:0], s[63] ^ s[62] ^ s[60] ^ s[59]};
  endfunction : lfsr

  // Left-part store: the top n source bytes fill the lanes from the addressed byte
  // down to the least significant lane; returns {byte enables, data}
  function automatic logic [71:0] left_exp(input logic [63:0] s, input logic [2:0] ofs, input logic big);
    int n;
    n = big ? 8 - int'(ofs) : int'(ofs) + 1;
    return {8'((9'h1 << n) - 9'h1), s >> (8 * (8 - n))};
  endfunction : left_exp

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // One store issued for a single cycle; results are read 1 ns after the taking edge
  task automatic issue(input logic [5:0] op, input logic [63:0] base, input logic [15:0] ofs, input logic [2:0] tlb);
    @(posedge sys_clk);
    dss_far_model_inst.general_register_file[1] <= base;
    dss_far_model_inst.general_register_file[2] <= src;
    instr_word <= {op, 5'h01, 5'h02, ofs};
    instr_valid <= 1'b1;
    {tlb_refill, tlb_invalid, tlb_modified} <= tlb;
    va = base + {{48{ofs[15]}}, ofs};
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    {tlb_refill, tlb_invalid, tlb_modified} <= 3'h0;
    #1;
  endtask : issue

  task automatic stored(input logic [63:0] data, input logic [7:0] be);
    chk("mem_wr", mem_wr, 1'b1);
    chk("mem_addr", mem_addr, {va[63:3] ^ PA_FLIP[63:3], 3'h0});
    chk("mem_data", mem_data, data);
    chk("mem_be", mem_be, be);
    chk("exc_valid", exc_valid, 1'b0);
  endtask : stored

  // An unusable coprocessor is not an address fault, so the last faulting address stays
  task automatic fault(input logic [3:0] code);
    if (code != dss_pkg::EXC_COP_UNUS) bva = va;
    chk("exc_valid", exc_valid, 1'b1);
    chk("exc_code", exc_code, code);
    chk("mem_wr", mem_wr, 1'b0);
    chk("bad_vaddr", bad_vaddr, bva);
  endtask : fault

  // One cycle of reservation events: 7 links, 1 exception, 2 system control, 3/4 snoop in/out of block
  task automatic pulse(input int e, input logic [63:0] pa);
    @(posedge sys_clk);
    linked_load <= (e == 7);
    linked_paddr <= pa;
    exc_taken <= (e == 1);
    sysctl_event <= (e == 2);
    snoop_store <= (e == 3 || e == 4);
    snoop_paddr <= pa ^ ((e == 3) ? 64'h18 : 64'h20);
    @(posedge sys_clk);
    {linked_load, exc_taken, sysctl_event, snoop_store} <= 4'h0;
    #1;
  endtask : pulse

  // Main sequence
  initial begin
    failures = 0; n_tests = 0; rnd = 64'h23; src = 64'h0; bva = 64'h0;
    sys_rst = 1'b1; instr_valid = 1'b0; instr_word = 32'h0; big_endian = 1'b0; cop_usable = 4'hF;
    {linked_load, exc_taken, sysctl_event, snoop_store, tlb_refill, tlb_invalid, tlb_modified} = 7'h0;
    linked_paddr = 64'h0; snoop_paddr = 64'h0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk("link_flag", link_flag, 1'b0);
    repeat (24) begin
      rnd = lfsr(rnd);
      src = rnd ^ 64'h5A5A_0000_0000_A5A5;
      rnd = lfsr(rnd);
      issue(dss_pkg::OP_PLAIN_DST, {rnd[63:3], 3'h0}, {rnd[20:8], 3'h0}, 3'h0);
      stored(src, 8'hFF);
    end
    issue(dss_pkg::OP_PLAIN_DST, 64'h0, 16'h8000, 3'h0);
    stored(src, 8'hFF);
    for (int m = 0; m < 3; m++) begin
      rnd = lfsr(rnd);
      issue(m == 0 ? dss_pkg::OP_COND_DST : m == 1 ? dss_pkg::OP_PLAIN_DST : {dss_pkg::OP_COP_HI, 2'h1},
            {rnd[63:3], 3'h0} | 64'(m + 1), 16'h0010, 3'h0);
      fault(dss_pkg::EXC_ADDR_ERR);
    end
    for (int t = 0; t < 4; t++) begin
      issue(dss_pkg::OP_PLAIN_DST, 64'h0001_0000, 16'hFFF8, t == 3 ? 3'h7 : 3'h4 >> t);
      fault(t == 3 ? dss_pkg::EXC_TLB_REF : dss_pkg::EXC_TLB_REF + 4'(t));
    end
    for (int z = 0; z < 8; z++) begin
      dss_far_model_inst.cop[z[1:0]] = 64'hC0C0_1234_0000_0000 + 64'(z);
      cop_usable <= z[2] ? 4'hF : ~(4'h1 << z[1:0]);
      issue({dss_pkg::OP_COP_HI, z[1:0]}, 64'h4000, 16'h0008, 3'h0);
      if (z[1:0] == 2'h0) begin
        chk("mem_wr", mem_wr, 1'b0);
        chk("exc_valid", exc_valid, 1'b0);
      end else if (z[1:0] == 2'h3) begin
        // Slot 3 is reused by the plain store, so the source register lands
        stored(src, 8'hFF);
      end else if (z[2]) begin
        stored(64'hC0C0_1234_0000_0000 + 64'(z), 8'hFF);
      end else begin
        fault(dss_pkg::EXC_COP_UNUS);
      end
    end
    for (int e = 0; e < 6; e++) begin
      rnd = lfsr(rnd);
      src = rnd;
      ok = (e == 0 || e == 4);
      if (e != 5) pulse(7, LBASE ^ PA_FLIP);
      pulse(e, LBASE ^ PA_FLIP);
      chk("link_flag", link_flag, ok);
      issue(dss_pkg::OP_COND_DST, LBASE, 16'h0, 3'h0);
      chk("gpr_wr", gpr_wr, 1'b1);
      chk("gpr_dst", gpr_dst, 5'h02);
      chk("gpr_data", gpr_data, 64'(ok));
      chk("mem_wr", mem_wr, ok);
      if (ok) stored(src, 8'hFF);
      chk("link_flag", link_flag, 1'b0);
    end
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      src = rnd;
      big_endian <= i[3];
      issue(dss_pkg::OP_LEFT_DST, 64'h0003_0000 + 64'(i[2:0]), 16'h0, 3'h0);
      lx = left_exp(src, i[2:0], i[3]);
      stored(lx[63:0], lx[71:64]);
    end
    report_and_stop();
  end

  // Watchdog: the sequence needs under two hundred cycles, this allows 4000
  initial begin
    #(25 * 4000);
    failures++;
    report_and_stop();
  end
endmodule : tb_dss_store_unit
